// >>> ppc_defines.vh
// Constants for the positioning program control block
// How it works
// - Start on a rising start input or a 0-to-1 start bit; controller makes the edge.
// - A started program runs to program end even if start is withdrawn.
// - Start still asserted at program end restarts the program automatically.
// - After interruption or fault a fresh start edge resumes, status code 15.
// - Start accepted only when ready, no faults, enabled, no fast stop, no manual, no reset.
// - Stop input or bit interrupts program, decelerating with set deceleration, no override.
// - Stop input and bit both low resume the program with the set profile.
// - Reset stops at maximum deceleration, ends program, clears counters, outputs, probes, stand-by.
// - Reset requested while inhibited is latched and done once the controller is enabled.
// - Cancel edge decelerates with cancel deceleration, then continues at jump target set.
// - Status outputs and code update only while ready, enabled, fault free, program mode.
// - Ready state shows ended, ready status and active set number 0.
// - Started state shows started; status tells control word start from input start.
// - Inhibit, fast stop, trip, mains failure or manual during a run gives started-break.
// - Started and started-break differ only in the status code.
// - Stand-by operation active never enters started-break.
// - Stopped state shows stopped; status tells control word stop from input stop.
// - Reset state shows reset and ended, set number 0, source in status.
// - Five variable tables: 104 positions, 34 speeds, accelerations, wait times, piece counts.
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

// =====================================================
// Register offsets
`define PPC_OFS_CONTROL 12'h000
`define PPC_OFS_STATUS 12'h004
`define PPC_OFS_MAX_DECEL 12'h008
`define PPC_OFS_CANCEL_DECEL 12'h00c
`define PPC_OFS_JUMP_SET 12'h010
`define PPC_TBL_REGION 2'h1

// =====================================================
// Control word bits
`define PPC_CW_START 0
`define PPC_CW_STOP 1
`define PPC_CW_RESET 2
`define PPC_CW_CANCEL 3
`define PPC_CW_MANUAL 4
`define PPC_CW_WIDTH 5

// =====================================================
// Status codes
`define PPC_SC_NONE 4'h0
`define PPC_SC_READY 4'h1
`define PPC_SC_STARTED 4'h2
`define PPC_SC_STARTED_REM 4'h3
`define PPC_SC_STARTED_DIG 4'h4
`define PPC_SC_BREAK 4'h5
`define PPC_SC_STOPPED 4'h6
`define PPC_SC_STOPPED_REM 4'h7
`define PPC_SC_STOPPED_DIG 4'h8
`define PPC_SC_RESET_REM 4'h9
`define PPC_SC_RESET_DIG 4'ha
`define PPC_SC_RESUMED 4'hf

// =====================================================
// Deceleration selection
`define PPC_DEC_NONE 2'h0
`define PPC_DEC_SET 2'h1
`define PPC_DEC_MAX 2'h2
`define PPC_DEC_CANCEL 2'h3

// =====================================================
// Variable tables
`define PPC_TBL_POS_SIZE 8'h68
`define PPC_TBL_SIZE 8'h22
`define PPC_TBL_TOTAL 240
`define PPC_TBL_LAST 8'hef
`define PPC_TBL_BASE_POS 8'h00
`define PPC_TBL_BASE_VEL 8'h68
`define PPC_TBL_BASE_ACC 8'h8a
`define PPC_TBL_BASE_TIME 8'hac
`define PPC_TBL_BASE_PCS 8'hce
`define PPC_SEL_POS 3'h0
`define PPC_SEL_VEL 3'h1
`define PPC_SEL_ACC 3'h2
`define PPC_SEL_TIME 3'h3
`define PPC_SEL_PCS 3'h4

// =====================================================
// Misc
`define PPC_SET_END 8'h00
`define PPC_ZERO32 32'h0000_0000

`endif

// >>> ppc_program_control.v
// Positioning program control state machine with APB registers and variable tables
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_program_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire program_start_in,
  input wire program_stop_in,
  input wire program_reset_in,
  input wire cancel_set_in,
  input wire manual_in,
  input wire [7:0] start_set_select_in,
  input wire power_stage_ready,
  input wire fault_trip,
  input wire fault_fast_stop,
  input wire controller_inhibit,
  input wire fast_stop_active,
  input wire mains_failure,
  input wire standby_active,
  input wire [7:0] seq_set_number,
  input wire seq_program_end,
  input wire [2:0] table_sel,
  input wire [6:0] table_index,
  output reg [31:0] table_data,
  output reg started_out,
  output reg stopped_out,
  output reg ended_out,
  output reg reset_done_out,
  output reg [3:0] positioning_status_code,
  output reg [7:0] active_set_number,
  output reg program_run,
  output reg load_start_set,
  output reg [1:0] decel_select,
  output reg accel_override_in_use,
  output reg [31:0] decel_value,
  output reg cancel_set_pulse,
  output reg [7:0] jump_target_set,
  output reg clear_piece_counter,
  output reg clear_function_outputs,
  output reg disable_touch_probe,
  output reg cancel_standby
);

  // =====================================================
  // States
  localparam [4:0] ST_READY = 5'h01;
  localparam [4:0] ST_STARTED = 5'h02;
  localparam [4:0] ST_BREAK = 5'h04;
  localparam [4:0] ST_STOPPED = 5'h08;
  localparam [4:0] ST_RESET = 5'h10;

  // =====================================================
  // Register file storage
  reg [`PPC_CW_WIDTH-1:0] control_word_q;
  reg [31:0] max_decel_param_q;
  reg [31:0] cancel_decel_param_q;
  reg [7:0] jump_set_param_q;
  reg [31:0] tbl_q [0:`PPC_TBL_TOTAL-1];

  // =====================================================
  // Control state
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg start_prev_q;
  reg cw_start_prev_q;
  reg cancel_prev_q;
  reg cw_cancel_prev_q;
  reg reset_pending_q;
  reg reset_src_cw_q;
  reg resumed_q;
  reg resumed_d;
  reg cancel_busy_q;

  // =====================================================
  // APB decode
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire in_tbl = (paddr[11:10] == `PPC_TBL_REGION);
  wire [7:0] bus_idx = paddr[9:2];
  wire tbl_hit = in_tbl & (bus_idx <= `PPC_TBL_LAST);
  wire hit_ctrl = (paddr == `PPC_OFS_CONTROL);
  wire hit_stat = (paddr == `PPC_OFS_STATUS);
  wire hit_maxd = (paddr == `PPC_OFS_MAX_DECEL);
  wire hit_cand = (paddr == `PPC_OFS_CANCEL_DECEL);
  wire hit_jump = (paddr == `PPC_OFS_JUMP_SET);
  wire mapped = hit_ctrl | hit_stat | hit_maxd | hit_cand | hit_jump | tbl_hit;
  wire wr_ok = access_ph & pwrite & mapped & ~hit_stat;

  assign pready = 1'b1;
  assign pslverr = access_ph & (~mapped | (pwrite & hit_stat));

  // =====================================================
  // Command conditions
  wire manual_on = manual_in | control_word_q[`PPC_CW_MANUAL];
  wire stop_req = program_stop_in | control_word_q[`PPC_CW_STOP];
  wire reset_req = program_reset_in | control_word_q[`PPC_CW_RESET];
  wire start_level = program_start_in | control_word_q[`PPC_CW_START];
  wire start_in_edge = program_start_in & ~start_prev_q;
  wire start_cw_edge = control_word_q[`PPC_CW_START] & ~cw_start_prev_q;
  wire start_edge = start_in_edge | start_cw_edge;
  wire cancel_edge = (cancel_set_in & ~cancel_prev_q) |
                     (control_word_q[`PPC_CW_CANCEL] & ~cw_cancel_prev_q);
  wire drive_enabled = power_stage_ready & ~fault_trip & ~fault_fast_stop &
                       ~controller_inhibit & ~fast_stop_active;
  wire start_ok = drive_enabled & ~manual_on & ~reset_req & ~reset_pending_q;
  wire reset_exec = reset_pending_q & drive_enabled;
  wire reset_enter = reset_exec & (state_q != ST_RESET);
  wire update_ok = drive_enabled & ~manual_on;
  wire interrupt = controller_inhibit | fast_stop_active | fault_trip |
                   fault_fast_stop | mains_failure | manual_on | ~power_stage_ready;
  wire go_break = interrupt & ~standby_active;

  // =====================================================
  // APB register writes and read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_word_q <= {`PPC_CW_WIDTH{1'b0}};
      max_decel_param_q <= `PPC_ZERO32;
      cancel_decel_param_q <= `PPC_ZERO32;
      jump_set_param_q <= `PPC_SET_END;
      prdata <= `PPC_ZERO32;
    end else begin
      if (wr_ok & hit_ctrl) control_word_q <= pwdata[`PPC_CW_WIDTH-1:0];
      if (wr_ok & hit_maxd) max_decel_param_q <= pwdata;
      if (wr_ok & hit_cand) cancel_decel_param_q <= pwdata;
      if (wr_ok & hit_jump) jump_set_param_q <= pwdata[7:0];
      if (setup_ph & ~pwrite) begin
        if (hit_ctrl) prdata <= {{(32-`PPC_CW_WIDTH){1'b0}}, control_word_q};
        else if (hit_stat) prdata <= {6'h00, resumed_q, reset_pending_q, active_set_number,
          reset_done_out, ended_out, stopped_out, started_out,
          positioning_status_code, 3'h0, state_q};
        else if (hit_maxd) prdata <= max_decel_param_q;
        else if (hit_cand) prdata <= cancel_decel_param_q;
        else if (hit_jump) prdata <= {24'h000000, jump_set_param_q};
        else if (tbl_hit) prdata <= tbl_q[bus_idx];
        else prdata <= `PPC_ZERO32;
      end
    end
  end

  // =====================================================
  // Variable tables, one flat array
  genvar g;
  generate
    for (g = 0; g < `PPC_TBL_TOTAL; g = g + 1) begin : g_tbl
      localparam [7:0] GI = g;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tbl_q[g] <= `PPC_ZERO32;
        end else if (wr_ok & tbl_hit & (bus_idx == GI)) begin
          tbl_q[g] <= pwdata;
        end
      end
    end
  endgenerate

  // Table read port for the profile generator
  reg [7:0] rd_base;
  wire [7:0] rd_size = (table_sel == `PPC_SEL_POS) ? `PPC_TBL_POS_SIZE :
                       (table_sel <= `PPC_SEL_PCS) ? `PPC_TBL_SIZE : 8'h00;
  wire [7:0] rd_idx = rd_base + {1'b0, table_index};
  wire rd_valid = ({1'b0, table_index} < rd_size);

  always @* begin
    case (table_sel)
      `PPC_SEL_POS: rd_base = `PPC_TBL_BASE_POS;
      `PPC_SEL_VEL: rd_base = `PPC_TBL_BASE_VEL;
      `PPC_SEL_ACC: rd_base = `PPC_TBL_BASE_ACC;
      `PPC_SEL_TIME: rd_base = `PPC_TBL_BASE_TIME;
      `PPC_SEL_PCS: rd_base = `PPC_TBL_BASE_PCS;
      default: rd_base = `PPC_TBL_BASE_POS;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_data <= `PPC_ZERO32;
    end else begin
      table_data <= rd_valid ? tbl_q[rd_idx] : `PPC_ZERO32;
    end
  end

  // =====================================================
  // State transitions
  always @* begin
    state_d = state_q;
    resumed_d = resumed_q;
    case (state_q)
      ST_READY: begin
        if (start_edge & start_ok) begin
          state_d = ST_STARTED;
          resumed_d = 1'b0;
        end
      end
      ST_STARTED: begin
        if (go_break) state_d = ST_BREAK;
        else if (stop_req) state_d = ST_STOPPED;
        else if (seq_program_end) begin
          if (start_level & start_ok) begin
            state_d = ST_STARTED;
            resumed_d = 1'b0;
          end else begin
            state_d = ST_READY;
          end
        end
      end
      ST_BREAK: begin
        if (start_edge & start_ok) begin
          state_d = ST_STARTED;
          resumed_d = 1'b1;
        end
      end
      ST_STOPPED: begin
        if (go_break) state_d = ST_BREAK;
        else if (~stop_req) state_d = ST_STARTED;
      end
      ST_RESET: begin
        if (~reset_req & ~reset_pending_q) state_d = ST_READY;
      end
      default: begin
        state_d = ST_READY;
      end
    endcase
    if (reset_exec) begin
      state_d = ST_RESET;
    end
  end

  // =====================================================
  // State and edge registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_READY;
      start_prev_q <= 1'b0;
      cw_start_prev_q <= 1'b0;
      cancel_prev_q <= 1'b0;
      cw_cancel_prev_q <= 1'b0;
      reset_pending_q <= 1'b0;
      reset_src_cw_q <= 1'b0;
      resumed_q <= 1'b0;
      cancel_busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      resumed_q <= resumed_d;
      start_prev_q <= program_start_in;
      cw_start_prev_q <= control_word_q[`PPC_CW_START];
      cancel_prev_q <= cancel_set_in;
      cw_cancel_prev_q <= control_word_q[`PPC_CW_CANCEL];
      reset_pending_q <= reset_req | (reset_pending_q & ~reset_exec);
      if (reset_req) begin
        reset_src_cw_q <= control_word_q[`PPC_CW_RESET];
      end
      if (cancel_edge & (state_q == ST_STARTED) & ~reset_exec) begin
        cancel_busy_q <= 1'b1;
      end else if (seq_program_end | (state_q != ST_STARTED)) begin
        cancel_busy_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // Drive commands to the profile and set sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_run <= 1'b0;
      load_start_set <= 1'b0;
      decel_select <= `PPC_DEC_NONE;
      accel_override_in_use <= 1'b0;
      decel_value <= `PPC_ZERO32;
      cancel_set_pulse <= 1'b0;
      jump_target_set <= `PPC_SET_END;
      clear_piece_counter <= 1'b0;
      clear_function_outputs <= 1'b0;
      disable_touch_probe <= 1'b0;
      cancel_standby <= 1'b0;
    end else begin
      program_run <= (state_d == ST_STARTED);
      load_start_set <= (state_q != ST_STARTED) & (state_d == ST_STARTED) & ~resumed_d |
                        (state_q == ST_STARTED) & seq_program_end & (state_d == ST_STARTED);
      cancel_set_pulse <= cancel_edge & (state_q == ST_STARTED) & ~reset_exec;
      jump_target_set <= jump_set_param_q;
      clear_piece_counter <= reset_enter;
      clear_function_outputs <= reset_enter;
      cancel_standby <= reset_enter;
      disable_touch_probe <= (state_d == ST_RESET);
      if (state_d == ST_RESET) begin
        decel_select <= `PPC_DEC_MAX;
        decel_value <= max_decel_param_q;
        accel_override_in_use <= 1'b0;
      end else if (state_d == ST_STOPPED) begin
        decel_select <= `PPC_DEC_SET;
        decel_value <= `PPC_ZERO32;
        accel_override_in_use <= 1'b0;
      end else if (cancel_busy_q | (cancel_edge & (state_q == ST_STARTED))) begin
        decel_select <= `PPC_DEC_CANCEL;
        decel_value <= cancel_decel_param_q;
        accel_override_in_use <= 1'b1;
      end else begin
        decel_select <= `PPC_DEC_NONE;
        decel_value <= `PPC_ZERO32;
        accel_override_in_use <= (state_d == ST_STARTED);
      end
    end
  end

  // =====================================================
  // Status outputs, frozen unless update conditions hold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_out <= 1'b0;
      stopped_out <= 1'b0;
      ended_out <= 1'b1;
      reset_done_out <= 1'b0;
      positioning_status_code <= `PPC_SC_READY;
      active_set_number <= `PPC_SET_END;
    end else if (update_ok) begin
      started_out <= (state_q == ST_STARTED) | (state_q == ST_BREAK);
      stopped_out <= (state_q == ST_STOPPED);
      ended_out <= (state_q == ST_READY) | (state_q == ST_RESET);
      reset_done_out <= (state_q == ST_RESET);
      case (state_q)
        ST_READY: begin
          positioning_status_code <= `PPC_SC_READY;
          active_set_number <= `PPC_SET_END;
        end
        ST_STARTED: begin
          if (resumed_q) begin
            positioning_status_code <= `PPC_SC_RESUMED;
          end else if (control_word_q[`PPC_CW_START]) begin
            positioning_status_code <= `PPC_SC_STARTED_REM;
          end else if (program_start_in) begin
            positioning_status_code <= `PPC_SC_STARTED_DIG;
          end else begin
            positioning_status_code <= `PPC_SC_STARTED;
          end
          active_set_number <= load_start_set ? start_set_select_in : seq_set_number;
        end
        ST_BREAK: begin
          positioning_status_code <= `PPC_SC_BREAK;
          active_set_number <= seq_set_number;
        end
        ST_STOPPED: begin
          if (control_word_q[`PPC_CW_STOP]) begin
            positioning_status_code <= `PPC_SC_STOPPED_REM;
          end else if (program_stop_in) begin
            positioning_status_code <= `PPC_SC_STOPPED_DIG;
          end else begin
            positioning_status_code <= `PPC_SC_STOPPED;
          end
          active_set_number <= seq_set_number;
        end
        ST_RESET: begin
          positioning_status_code <= reset_src_cw_q ? `PPC_SC_RESET_REM :
                                                     `PPC_SC_RESET_DIG;
          active_set_number <= `PPC_SET_END;
        end
        default: begin
          positioning_status_code <= `PPC_SC_NONE;
          active_set_number <= `PPC_SET_END;
        end
      endcase
    end
  end

endmodule // ppc_program_control

`default_nettype wire

// >>> ppc_plc_model.sv
// Controller model that drives the program command lines
`timescale 1ns/1ps
`default_nettype none
module ppc_plc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] cmd,
  output logic program_start_in,
  output logic program_stop_in,
  output logic program_reset_in,
  output logic cancel_set_in,
  output logic manual_in
);
  // ==========================================
  // Command levels change just after a clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {manual_in, cancel_set_in, program_reset_in, program_stop_in, program_start_in} <= 5'h00;
    end else begin
      {manual_in, cancel_set_in, program_reset_in, program_stop_in, program_start_in} <= cmd;
    end
  end
endmodule // ppc_plc_model
`default_nettype wire

// >>> ppc_checker.sv
// Assertions on the program control ports
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"
module ppc_checker (
  input wire pclk,
  input wire presetn,
  input wire program_reset_in,
  input wire cancel_set_in,
  input wire manual_in,
  input wire power_stage_ready,
  input wire fault_trip,
  input wire fault_fast_stop,
  input wire controller_inhibit,
  input wire fast_stop_active,
  input wire started_out,
  input wire stopped_out,
  input wire ended_out,
  input wire reset_done_out,
  input wire [3:0] positioning_status_code,
  input wire [7:0] active_set_number,
  input wire program_run,
  input wire load_start_set,
  input wire cancel_set_pulse,
  input wire clear_piece_counter,
  input wire clear_function_outputs,
  input wire cancel_standby
);
  wire upd = power_stage_ready && !fault_trip && !fault_fast_stop && !controller_inhibit
    && !fast_stop_active && !manual_in;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Sequences and properties
  sequence s_frozen;
    !upd [*2] ##1 1'b1;
  endsequence
  sequence s_clear;
    clear_function_outputs && cancel_standby ##1 !clear_piece_counter;
  endsequence
  property p_ready;
    positioning_status_code == `PPC_SC_READY |-> ended_out && active_set_number == 8'h00;
  endproperty
  property p_started;
    positioning_status_code inside {`PPC_SC_STARTED, `PPC_SC_STARTED_REM, `PPC_SC_STARTED_DIG}
      |-> started_out && !ended_out;
  endproperty
  property p_break;
    positioning_status_code == `PPC_SC_BREAK |-> started_out;
  endproperty
  property p_stopped;
    positioning_status_code inside {`PPC_SC_STOPPED, `PPC_SC_STOPPED_REM, `PPC_SC_STOPPED_DIG}
      |-> stopped_out;
  endproperty
  property p_reset;
    positioning_status_code inside {`PPC_SC_RESET_REM, `PPC_SC_RESET_DIG}
      |-> reset_done_out && ended_out && active_set_number == 8'h00;
  endproperty
  property p_frozen;
    s_frozen |-> $stable(started_out) && $stable(stopped_out) && $stable(ended_out)
      && $stable(reset_done_out) && $stable(positioning_status_code);
  endproperty
  property p_clear;
    clear_piece_counter |-> s_clear;
  endproperty
  property p_run;
    $rose(program_run) |-> $past(upd) && !$past(program_reset_in);
  endproperty
  property p_load;
    load_start_set |-> program_run;
  endproperty
  property p_cancel;
    cancel_set_pulse |-> ($past(cancel_set_in) || $past(cancel_set_in, 2)) ##1 !cancel_set_pulse;
  endproperty
  a_ready: assert property (p_ready) else $error("ready flags wrong");
  a_started: assert property (p_started) else $error("started flags wrong");
  a_break: assert property (p_break) else $error("break flags wrong");
  a_stopped: assert property (p_stopped) else $error("stopped flag wrong");
  a_reset: assert property (p_reset) else $error("reset flags wrong");
  a_frozen: assert property (p_frozen) else $error("status moved while frozen");
  a_clear: assert property (p_clear) else $error("reset pulses wrong");
  a_run: assert property (p_run) else $error("start taken while blocked");
  a_load: assert property (p_load) else $error("load without run");
  a_cancel: assert property (p_cancel) else $error("cancel pulse wrong");
endmodule // ppc_checker
bind ppc_program_control ppc_checker u_ppc_checker (.*);
`default_nettype wire

// >>> positioning_program_control_test.sv
// Bench for the program control block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"
module positioning_program_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_program_end;
  logic program_start_in, program_stop_in, program_reset_in, cancel_set_in, manual_in;
  logic power_stage_ready, fault_trip, fault_fast_stop, controller_inhibit, fast_stop_active;
  logic mains_failure, standby_active, started_out, stopped_out, ended_out, reset_done_out;
  logic program_run, load_start_set, accel_override_in_use, cancel_set_pulse, cancel_standby;
  logic clear_piece_counter, clear_function_outputs, disable_touch_probe;
  logic [1:0] decel_select;
  logic [2:0] table_sel;
  logic [3:0] positioning_status_code;
  logic [4:0] cmd;
  logic [6:0] env, table_index;
  logic [7:0] start_set_select_in, seq_set_number, active_set_number, jump_target_set;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, table_data, decel_value, mx, cx, v;
  logic [33:0] nt, q[$];
  logic [6:0] brk[5] = '{7'h09, 7'h11, 7'h03, 7'h05, 7'h21};
  int sz[5] = '{104, 34, 34, 34, 34};
  int bad_count, cmp_count, cyc_n, n_cancel, n_load, n_clear, base;
  assign {standby_active, mains_failure, fast_stop_active, controller_inhibit, fault_fast_stop,
    fault_trip, power_stage_ready} = env;
  ppc_plc_model u_ppc_plc_model (.*);
  ppc_program_control u_ppc_program_control (.*);
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic st(input logic [3:0] c, input logic s, input logic p, input logic e);
    chk("code", positioning_status_code, c);
    chk("started", started_out, s);
    chk("stopped", stopped_out, p);
    chk("ended", ended_out, e);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    q.push_back({!w, er, d});
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic pend();
    seq_program_end <= 1'h1;
    @(posedge pclk);
    seq_program_end <= 1'h0;
    cyc(4);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Monitor and timeout
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      nt = q.pop_front();
      chk("pslverr", pslverr, nt[32]);
      if (nt[33]) chk("prdata", prdata, nt[31:0]);
    end
    if (cancel_set_pulse) begin
      n_cancel++;
      chk("cancel decel", decel_value, cx);
    end
    if (load_start_set) n_load++;
    if (clear_piece_counter) n_clear++;
    cyc_n++;
    if (cyc_n > 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'h0;
    env = 7'h01;
    {psel, penable, pwrite, paddr, pwdata, cmd, seq_program_end} = '0;
    {table_sel, table_index, start_set_select_in, seq_set_number} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    void'($urandom(8));
    @(posedge pclk);
    st(`PPC_SC_READY, 0, 0, 1);
    chk("set", active_set_number, 0);
    $display("reset values done");
    mx = $urandom;
    cx = $urandom;
    v = $urandom_range(255, 1);
    apb(1, `PPC_OFS_MAX_DECEL, mx, 0);
    apb(1, `PPC_OFS_CANCEL_DECEL, cx, 0);
    apb(1, `PPC_OFS_JUMP_SET, v, 0);
    apb(0, `PPC_OFS_MAX_DECEL, mx, 0);
    apb(0, `PPC_OFS_JUMP_SET, v, 0);
    apb(0, 12'h020, 0, 1);
    apb(1, `PPC_OFS_STATUS, 32'h0000_001f, 1);
    chk("jump", jump_target_set, v);
    base = 0;
    foreach (sz[k]) begin
      v = $urandom;
      apb(1, 12'h400 + 12'(4 * (base + sz[k] - 1)), v, 0);
      table_sel <= 3'(k);
      table_index <= 7'(sz[k] - 1);
      cyc(2);
      chk("table", table_data, v);
      table_index <= 7'(sz[k]);
      cyc(2);
      chk("table end", table_data, 0);
      base += sz[k];
    end
    $display("registers done");
    for (int k = 0; k < 6; k++) begin
      env <= (k == 0) ? 7'h00 : (k == 5) ? 7'h01 : (7'h01 | (7'h01 << k));
      cmd <= (k == 5) ? 5'h10 : 5'h00;
      cyc(2);
      cmd <= (k == 5) ? 5'h11 : 5'h01;
      cyc(4);
      chk("run", program_run, 0);
      cmd <= 5'h00;
      env <= 7'h01;
      cyc(3);
    end
    $display("refused starts done");
    v = $urandom_range(255, 1);
    start_set_select_in <= v[7:0];
    cmd <= 5'h01;
    cyc(4);
    st(`PPC_SC_STARTED_DIG, 1, 0, 0);
    chk("set", active_set_number, v);
    cmd <= 5'h00;
    cyc(6);
    chk("run", program_run, 1);
    cmd <= 5'h02;
    cyc(4);
    chk("code", positioning_status_code, `PPC_SC_STOPPED_DIG);
    chk("stopped", stopped_out, 1);
    chk("decel", decel_select, `PPC_DEC_SET);
    chk("override", accel_override_in_use, 0);
    cmd <= 5'h00;
    cyc(4);
    chk("stopped", stopped_out, 0);
    chk("started", started_out, 1);
    apb(1, `PPC_OFS_CONTROL, 32'h0000_0002, 0);
    cyc(4);
    chk("code", positioning_status_code, `PPC_SC_STOPPED_REM);
    apb(1, `PPC_OFS_CONTROL, 0, 0);
    cyc(4);
    n_cancel = 0;
    cmd <= 5'h08;
    cyc(4);
    chk("cancels", n_cancel, 1);
    cmd <= 5'h00;
    $display("start stop cancel done");
    seq_set_number <= $urandom;
    cmd <= 5'h01;
    cyc(2);
    n_load = 0;
    pend();
    chk("restart", n_load, 1);
    chk("started", started_out, 1);
    cmd <= 5'h00;
    cyc(2);
    pend();
    st(`PPC_SC_READY, 0, 0, 1);
    chk("set", active_set_number, 0);
    apb(1, `PPC_OFS_CONTROL, 32'h0000_0001, 0);
    cyc(4);
    chk("code", positioning_status_code, `PPC_SC_STARTED_REM);
    apb(1, `PPC_OFS_CONTROL, 0, 0);
    $display("program end done");
    foreach (brk[k]) begin
      env <= brk[k];
      cyc(3);
      env <= 7'h01;
      cyc(4);
      st(`PPC_SC_BREAK, 1, 0, 0);
      cmd <= 5'h01;
      cyc(4);
      chk("code", positioning_status_code, `PPC_SC_RESUMED);
      cmd <= 5'h00;
      cyc(2);
    end
    env <= 7'h49;
    cyc(3);
    env <= 7'h41;
    cyc(4);
    chk("no break", positioning_status_code == `PPC_SC_BREAK, 0);
    env <= 7'h01;
    $display("interruptions done");
    n_clear = 0;
    env <= 7'h09;
    cmd <= 5'h04;
    cyc(5);
    chk("clears", n_clear, 0);
    env <= 7'h01;
    cyc(6);
    chk("clears", n_clear, 1);
    st(`PPC_SC_RESET_DIG, 0, 0, 1);
    chk("reset done", reset_done_out, 1);
    chk("set", active_set_number, 0);
    chk("probe", disable_touch_probe, 1);
    chk("decel", decel_select, `PPC_DEC_MAX);
    chk("decel value", decel_value, mx);
    cmd <= 5'h00;
    cyc(6);
    st(`PPC_SC_READY, 0, 0, 1);
    cmd <= 5'h05;
    cyc(5);
    chk("run", program_run, 0);
    cmd <= 5'h00;
    cyc(6);
    apb(1, `PPC_OFS_CONTROL, 32'h0000_0004, 0);
    cyc(6);
    chk("code", positioning_status_code, `PPC_SC_RESET_REM);
    apb(1, `PPC_OFS_CONTROL, 0, 0);
    cyc(6);
    $display("reset done");
    print_verdict();
  end
endmodule // positioning_program_control_test
`default_nettype wire
